// ==== hw/csrb_cfg.svh ====
// Offsets, field positions and widths of the charger status register bank
`ifndef CSRB_CFG_SVH
`define CSRB_CFG_SVH

`define CSRB_DATA_W          8
`define CSRB_OFS_CHARGE      8'h0B
`define CSRB_OFS_SOURCE      8'h0C
`define CSRB_OFS_THERM       8'h0D
`define CSRB_OFS_FAULT       8'h0E
`define CSRB_UNMAPPED_VAL    8'h00
`define CSRB_RSVD_BIT        1'b0

`define CSRB_PHASE_W         3
`define CSRB_SRC_W           3
`define CSRB_SEARCH_W        2
`define CSRB_ZONE_W          3
`define CSRB_ZONE_PAD_W      5

`define CSRB_CH_DONE         7
`define CSRB_CH_IIN          6
`define CSRB_CH_VIN          5
`define CSRB_CH_TREG         4
`define CSRB_CH_WD           3
`define CSRB_CH_PHASE_LSB    0

`define CSRB_SRC_PG          7
`define CSRB_SRC_CODE_LSB    4
`define CSRB_SRC_RSVD        3
`define CSRB_SRC_SEARCH_LSB  1
`define CSRB_SRC_MINSYS      0

`define CSRB_TH_ZONE_LSB     0
`define CSRB_TH_PAD_LSB      3

`define CSRB_FLT_VOVP        7
`define CSRB_FLT_TSHUT       6
`define CSRB_FLT_BOVP        5
`define CSRB_FLT_TMR         4
`define CSRB_FLT_RSVD_LSB    0
`define CSRB_FLT_RSVD_W      4

// Width of the bundle of asynchronous status pins
`define CSRB_ANA_W           21

`endif

// ==== hw/csrb_pkg.sv ====
// Types shared by the charger status register bank
`include "csrb_cfg.svh"
package csrb_pkg;
    typedef logic [`CSRB_DATA_W-1:0]   csrb_byte_t;
    typedef logic [`CSRB_PHASE_W-1:0]  csrb_phase_t;
    typedef logic [`CSRB_SRC_W-1:0]    csrb_source_t;
    typedef logic [`CSRB_SEARCH_W-1:0] csrb_search_t;
    typedef logic [`CSRB_ZONE_W-1:0]   csrb_zone_t;
    typedef logic [`CSRB_ANA_W-1:0]    csrb_ana_t;
endpackage : csrb_pkg

// ==== hw/csrb_sync.sv ====
// Two-flop synchroniser for a bundle of status levels
`timescale 1ns/10ps
module csrb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule : csrb_sync

// ==== hw/csrb_status_bank.sv ====
// Read-only charger status register bank with change-event detection
`timescale 1ns/10ps
`include "csrb_cfg.svh"
module csrb_status_bank (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  conv_oneshot_mode,
    input  wire logic                  host_timer_expired,
    input  wire logic                  conv_done_in,
    input  wire logic                  input_current_limit_active,
    input  wire logic                  input_voltage_limit_active,
    input  wire logic                  die_thermal_regulation_active,
    input  wire csrb_pkg::csrb_phase_t charge_phase_code_in,
    input  wire logic                  supply_good_in,
    input  wire csrb_pkg::csrb_source_t input_source_code_in,
    input  wire csrb_pkg::csrb_search_t current_search_state_in,
    input  wire logic                  min_system_regulation_in,
    input  wire csrb_pkg::csrb_zone_t  thermistor_zone_code_in,
    input  wire logic                  input_overvoltage_in,
    input  wire logic                  thermal_shutdown_in,
    input  wire logic                  battery_overvoltage_in,
    input  wire logic                  safety_timer_expired_in,
    input  wire logic                  rd_en,
    input  wire csrb_pkg::csrb_byte_t  rd_addr,
    output csrb_pkg::csrb_byte_t       rd_data,
    output logic                       rd_valid,
    output logic                       input_current_limit_event,
    output logic                       input_voltage_limit_event,
    output logic                       thermal_regulation_event,
    output logic                       host_timer_event,
    output logic                       charge_phase_event
);
    import csrb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    // Multi-bit codes are synchronised bit by bit; a code caught mid-change
    // may raise one extra phase event, which is cheaper than a handshake.
    csrb_ana_t    ana_raw;
    csrb_ana_t    ana_s;
    logic         conv_done_s;
    logic         iin_s;
    logic         vin_s;
    logic         treg_s;
    logic         pg_s;
    logic         minsys_s;
    logic         vovp_s;
    logic         tshut_s;
    logic         bovp_s;
    logic         tmr_s;
    csrb_phase_t  phase_s;
    csrb_source_t source_s;
    csrb_search_t search_s;
    csrb_zone_t   zone_s;

    assign ana_raw = {conv_done_in, input_current_limit_active, input_voltage_limit_active,
                      die_thermal_regulation_active, supply_good_in, min_system_regulation_in,
                      input_overvoltage_in, thermal_shutdown_in, battery_overvoltage_in,
                      safety_timer_expired_in, charge_phase_code_in, input_source_code_in,
                      current_search_state_in, thermistor_zone_code_in};

    csrb_sync #(
        .WIDTH    (`CSRB_ANA_W)
    ) u_sync (
        .clk      (clk),
        .rst_b    (rst_b),
        .async_in (ana_raw),
        .sync_out (ana_s)
    );

    assign {conv_done_s, iin_s, vin_s, treg_s, pg_s, minsys_s, vovp_s, tshut_s, bovp_s,
            tmr_s, phase_s, source_s, search_s, zone_s} = ana_s;

    ////////////////////////////////////////////////////////////////////////////
    // Register images
    // No write path exists, so soft resets and writes cannot disturb them
    csrb_byte_t charge_img;
    csrb_byte_t source_img;
    csrb_byte_t therm_img;
    csrb_byte_t fault_img;
    csrb_byte_t rd_mux;

    assign charge_img[`CSRB_CH_DONE] = conv_oneshot_mode & conv_done_s;
    assign charge_img[`CSRB_CH_IIN]  = iin_s;
    assign charge_img[`CSRB_CH_VIN]  = vin_s;
    assign charge_img[`CSRB_CH_TREG] = treg_s;
    assign charge_img[`CSRB_CH_WD]   = host_timer_expired;
    assign charge_img[`CSRB_CH_PHASE_LSB +: `CSRB_PHASE_W] = phase_s;

    assign source_img[`CSRB_SRC_PG]  = pg_s;
    assign source_img[`CSRB_SRC_CODE_LSB +: `CSRB_SRC_W] = source_s;
    assign source_img[`CSRB_SRC_RSVD] = `CSRB_RSVD_BIT;
    assign source_img[`CSRB_SRC_SEARCH_LSB +: `CSRB_SEARCH_W] = search_s;
    assign source_img[`CSRB_SRC_MINSYS] = minsys_s;

    assign therm_img[`CSRB_TH_ZONE_LSB +: `CSRB_ZONE_W] = zone_s;
    assign therm_img[`CSRB_TH_PAD_LSB +: `CSRB_ZONE_PAD_W] = '0;

    assign fault_img[`CSRB_FLT_VOVP]  = vovp_s;
    assign fault_img[`CSRB_FLT_TSHUT] = tshut_s;
    assign fault_img[`CSRB_FLT_BOVP]  = bovp_s;
    assign fault_img[`CSRB_FLT_TMR]   = tmr_s;
    assign fault_img[`CSRB_FLT_RSVD_LSB +: `CSRB_FLT_RSVD_W] = '0;

    // Live selection; unmapped offsets answer zero
    assign rd_mux = (rd_addr == `CSRB_OFS_CHARGE) ? charge_img :
                    (rd_addr == `CSRB_OFS_SOURCE) ? source_img :
                    (rd_addr == `CSRB_OFS_THERM)  ? therm_img  :
                    (rd_addr == `CSRB_OFS_FAULT)  ? fault_img  : `CSRB_UNMAPPED_VAL;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data  <= `CSRB_UNMAPPED_VAL;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_mux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event detection
    logic        iin_prev_r;
    logic        vin_prev_r;
    logic        treg_prev_r;
    logic        wd_prev_r;
    csrb_phase_t phase_prev_r;
    logic        iin_rise;
    logic        vin_rise;
    logic        treg_rise;
    logic        wd_rise;
    logic        phase_change;

    assign iin_rise     = iin_s & ~iin_prev_r;
    assign vin_rise     = vin_s & ~vin_prev_r;
    assign treg_rise    = treg_s & ~treg_prev_r;
    assign wd_rise      = host_timer_expired & ~wd_prev_r;
    assign phase_change = phase_s != phase_prev_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            iin_prev_r   <= 1'b0;
            vin_prev_r   <= 1'b0;
            treg_prev_r  <= 1'b0;
            wd_prev_r    <= 1'b0;
            phase_prev_r <= '0;
        end else begin
            iin_prev_r   <= iin_s;
            vin_prev_r   <= vin_s;
            treg_prev_r  <= treg_s;
            wd_prev_r    <= host_timer_expired;
            phase_prev_r <= phase_s;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_current_limit_event <= 1'b0;
            input_voltage_limit_event <= 1'b0;
            thermal_regulation_event  <= 1'b0;
            host_timer_event          <= 1'b0;
            charge_phase_event        <= 1'b0;
        end else begin
            input_current_limit_event <= iin_rise;
            input_voltage_limit_event <= vin_rise;
            thermal_regulation_event  <= treg_rise;
            host_timer_event          <= wd_rise;
            charge_phase_event        <= phase_change;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_rd_charge;
        rd_en && rd_addr == `CSRB_OFS_CHARGE;
    endsequence
    sequence s_rd_source;
        rd_en && rd_addr == `CSRB_OFS_SOURCE;
    endsequence
    sequence s_rd_therm;
        rd_en && rd_addr == `CSRB_OFS_THERM;
    endsequence
    sequence s_rd_fault;
        rd_en && rd_addr == `CSRB_OFS_FAULT;
    endsequence

    a_done_cont_zero: assert property (s_rd_charge ##0 !conv_oneshot_mode |=>
        !rd_data[`CSRB_CH_DONE] && rd_valid) else $error("done bit set in continuous mode");
    a_iin_vin_bits: assert property (s_rd_charge |=>
        rd_data[`CSRB_CH_IIN] == $past(input_current_limit_active, 3)
        && rd_data[`CSRB_CH_VIN] == $past(input_voltage_limit_active, 3))
        else $error("limit bits do not follow pins");
    a_treg_bit: assert property (s_rd_charge |=>
        rd_data[`CSRB_CH_TREG] == $past(die_thermal_regulation_active, 3))
        else $error("thermal regulation bit wrong");
    a_wd_bit: assert property (s_rd_charge |=>
        rd_data[`CSRB_CH_WD] == $past(host_timer_expired)) else $error("watchdog bit wrong");
    a_phase_field: assert property (s_rd_charge |=>
        rd_data[`CSRB_CH_PHASE_LSB +: `CSRB_PHASE_W] == $past(charge_phase_code_in, 3))
        else $error("charge phase field wrong");
    a_source_field: assert property (s_rd_source |=>
        rd_data[`CSRB_SRC_CODE_LSB +: `CSRB_SRC_W] == $past(input_source_code_in, 3))
        else $error("source field wrong");
    a_search_field: assert property (s_rd_source |=>
        rd_data[`CSRB_SRC_SEARCH_LSB +: `CSRB_SEARCH_W] == $past(current_search_state_in, 3))
        else $error("search field wrong");
    a_minsys_bit: assert property (s_rd_source |=>
        rd_data[`CSRB_SRC_MINSYS] == $past(min_system_regulation_in, 3))
        else $error("minimum system bit wrong");
    a_vovp_bit: assert property (s_rd_fault |=>
        rd_data[`CSRB_FLT_VOVP] == $past(input_overvoltage_in, 3)) else $error("vovp bit wrong");
    a_tshut_bit: assert property (s_rd_fault |=>
        rd_data[`CSRB_FLT_TSHUT] == $past(thermal_shutdown_in, 3)) else $error("tshut bit wrong");
    a_bovp_bit: assert property (s_rd_fault |=>
        rd_data[`CSRB_FLT_BOVP] == $past(battery_overvoltage_in, 3)) else $error("bovp bit wrong");
    a_tmr_bit: assert property (s_rd_fault |=>
        rd_data[`CSRB_FLT_TMR] == $past(safety_timer_expired_in, 3))
        else $error("timer bit wrong");
    // Each register has its own reserved layout, so the checks stay apart
    a_rsvd_zero: assert property (s_rd_source |=> !rd_data[`CSRB_SRC_RSVD])
        else $error("source reserved bit not zero");
    a_flt_rsvd_zero: assert property (s_rd_fault |=>
        rd_data[`CSRB_FLT_RSVD_LSB +: `CSRB_FLT_RSVD_W] == '0)
        else $error("fault reserved bits not zero");
    a_zone_field: assert property (s_rd_therm |=>
        rd_data == {{`CSRB_ZONE_PAD_W{1'b0}}, $past(thermistor_zone_code_in, 3)})
        else $error("thermistor register wrong");
    a_idle_holds: assert property (!rd_en |=> $stable(rd_data) && !rd_valid)
        else $error("read data moved without a read");
    a_pg_bit: assert property (s_rd_source |=>
        rd_data[`CSRB_SRC_PG] == $past(supply_good_in, 3)) else $error("power good bit wrong");
    a_iin_event: assert property ($rose(iin_s) |=> input_current_limit_event ##1
        !input_current_limit_event) else $error("current limit event missing");
    a_wd_event: assert property (host_timer_event |-> $past(host_timer_expired)
        && !$past(host_timer_expired, 2)) else $error("spurious watchdog event");
    a_phase_event: assert property ($changed(phase_s) |=> charge_phase_event)
        else $error("phase change event missing");
endmodule : csrb_status_bank

// ==== sim/csrb_host_model.sv ====
// Host-side reader model that turns a request pulse into one register read
`timescale 1ns/10ps
module csrb_host_model (
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    input  wire logic                 req,
    input  wire csrb_pkg::csrb_byte_t req_addr,
    input  wire logic [1:0]           slow,
    output logic                      rd_en,
    output csrb_pkg::csrb_byte_t      rd_addr,
    input  wire csrb_pkg::csrb_byte_t rd_data,
    input  wire logic                 rd_valid,
    output csrb_pkg::csrb_byte_t      rsp_data,
    output logic                      rsp_done
);
    import csrb_pkg::*;
    logic [2:0] wait_r;
    csrb_byte_t held_r;
    ////////////////////////////////////////////////////////////////////////
    // Slow setting delays the read, as a busy host would
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_r   <= 3'h0;
            held_r   <= 8'h00;
            rd_en    <= 1'b0;
            rd_addr  <= 8'h00;
            rsp_data <= 8'h00;
            rsp_done <= 1'b0;
        end else begin
            rsp_done <= rd_valid;
            rd_en    <= (wait_r == 3'h1);
            if (rd_valid) begin
                rsp_data <= rd_data;
            end
            if (req) begin
                wait_r <= {1'b0, slow} + 3'h1;
                held_r <= req_addr;
            end else if (wait_r != 3'h0) begin
                wait_r <= wait_r - 3'h1;
            end
            // Address inverted once after each read so a stale value is never trusted
            if (wait_r == 3'h1) begin
                rd_addr <= held_r;
            end else if (rd_en) begin
                rd_addr <= ~rd_addr;
            end
        end
    end
endmodule : csrb_host_model

// ==== sim/tb_csrb_status_bank.sv ====
// Self-checking bench for the charger status register bank
`timescale 1ns/10ps
module tb_csrb_status_bank;
    import csrb_pkg::*;
    logic         clk, rst_b, mode, wd, done, iin, vin, treg, pg, minsys;
    logic         vovp, tsh, bovp, tmr, req, rd_en, rd_valid, rsp_done;
    logic         e_iin, e_vin, e_treg, e_wd, e_ph;
    logic [1:0]   slow;
    csrb_phase_t  phase;
    csrb_source_t src;
    csrb_search_t srch;
    csrb_zone_t   zone;
    csrb_byte_t   req_addr, rd_addr, rd_data, rsp_data;
    int           error_cnt, checks, n_iin, n_vin, n_treg, n_wd, n_ph;
    initial clk = 1'b0;
    always #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////
    csrb_status_bank u_csrb_status_bank (
        .clk(clk), .rst_b(rst_b), .conv_oneshot_mode(mode), .host_timer_expired(wd),
        .conv_done_in(done), .input_current_limit_active(iin),
        .input_voltage_limit_active(vin), .die_thermal_regulation_active(treg),
        .charge_phase_code_in(phase), .supply_good_in(pg), .input_source_code_in(src),
        .current_search_state_in(srch), .min_system_regulation_in(minsys),
        .thermistor_zone_code_in(zone), .input_overvoltage_in(vovp),
        .thermal_shutdown_in(tsh), .battery_overvoltage_in(bovp),
        .safety_timer_expired_in(tmr), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .input_current_limit_event(e_iin),
        .input_voltage_limit_event(e_vin), .thermal_regulation_event(e_treg),
        .host_timer_event(e_wd), .charge_phase_event(e_ph));
    csrb_host_model u_csrb_host_model (
        .clk(clk), .rst_b(rst_b), .req(req), .req_addr(req_addr), .slow(slow),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
        .rsp_data(rsp_data), .rsp_done(rsp_done));
    always @(posedge clk) begin
        n_iin  <= n_iin + int'(e_iin);
        n_vin  <= n_vin + int'(e_vin);
        n_treg <= n_treg + int'(e_treg);
        n_wd   <= n_wd + int'(e_wd);
        n_ph   <= n_ph + int'(e_ph);
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input csrb_byte_t seen, input csrb_byte_t exp, input string what);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Waits a bounded time for the reader, then compares
    task automatic rd_chk(input csrb_byte_t a, input csrb_byte_t e, input string what);
        int k;
        @(posedge clk);
        req      <= 1'b1;
        req_addr <= a;
        @(posedge clk);
        req <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (rsp_done !== 1'b1 && k < 20);
        // A read that never answers must not pass on stale data
        chk({7'h00, rsp_done}, 8'h01, "read answered");
        chk(rsp_data, e, what);
    endtask : rd_chk
    task automatic summarize();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    task automatic t_idle();
        @(posedge clk);
        #1;
        chk({7'h00, rd_valid}, 8'h00, "valid after reset");
        chk(8'(n_iin + n_vin + n_treg + n_wd + n_ph), 8'h00, "events at rest");
        rd_chk(8'h0A, 8'h00, "below bank");
        rd_chk(8'h0F, 8'h00, "above bank");
    endtask : t_idle
    // Two rises and two falls per level: one pulse per rise only
    task automatic t_events();
        int b0, b1, b2, b3;
        b0 = n_iin;
        b1 = n_vin;
        b2 = n_treg;
        b3 = n_wd;
        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            {iin, vin, treg, wd} <= 4'hF;
            repeat (6) @(posedge clk);
            {iin, vin, treg, wd} <= 4'h0;
            repeat (6) @(posedge clk);
        end
        #1;
        chk(8'(n_iin - b0), 8'h02, "current limit events");
        chk(8'(n_vin - b1), 8'h02, "voltage limit events");
        chk(8'(n_treg - b2), 8'h02, "thermal events");
        chk(8'(n_wd - b3), 8'h02, "watchdog events");
    endtask : t_events
    // Every phase code, every flag mix, done with and without one-shot
    task automatic t_charge();
        int b;
        b = n_ph;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {mode, done, phase, iin, vin, treg, wd} <= {i[3], ~i[0], i[2:0], i[3:0]};
            repeat (2) @(posedge clk);
            rd_chk(8'h0B, {i[3] & ~i[0], i[3:0], i[2:0]}, "charge reg");
        end
        repeat (4) @(posedge clk);
        #1;
        chk(8'(n_ph - b), 8'h0F, "phase events");
    endtask : t_charge
    task automatic t_source();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {pg, src, srch, minsys} <= {i[0], i[2:0], i[1:0], ~i[0]};
            repeat (2) @(posedge clk);
            rd_chk(8'h0C, {i[0], i[2:0], 1'b0, i[1:0], ~i[0]}, "source reg");
        end
    endtask : t_source
    // Host answers slowly here
    task automatic t_therm();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            slow <= 2'h3;
            zone <= i[2:0];
            repeat (2) @(posedge clk);
            rd_chk(8'h0D, {5'h00, i[2:0]}, "zone reg");
        end
        @(posedge clk);
        slow <= 2'h0;
    endtask : t_therm
    task automatic t_fault();
        for (int i = 0; i < 17; i++) begin
            @(posedge clk);
            {vovp, tsh, bovp, tmr} <= i[3:0];
            repeat (2) @(posedge clk);
            rd_chk(8'h0E, {i[3:0], 4'h0}, "fault reg");
        end
    endtask : t_fault
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {mode, wd, done, iin, vin, treg, pg, minsys, vovp, tsh, bovp, tmr, req} = '0;
        {phase, src, srch, zone, slow} = '0;
        req_addr = 8'h00;
        rst_b = 1'b0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_idle();
        t_events();
        t_charge();
        t_source();
        t_therm();
        t_fault();
        summarize();
    end
    // Whole run needs under 2000 cycles
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule : tb_csrb_status_bank
